// File: siu_pkg.sv
package siu_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_ID = 8'h00;
   localparam logic [7:0] ADDR_COND = 8'h01;
   localparam logic [7:0] ADDR_FLAGS = 8'h02;
   localparam logic [7:0] ADDR_MASK = 8'h03;
   localparam logic [7:0] ADDR_CTRL2 = 8'h05;

   // ----------------------------------------
   // Values and field positions
   // ----------------------------------------
   localparam logic [15:0] RESET_MAGIC = 16'h55AA;
   localparam logic [15:0] MASK_RST = 16'hFFFF;
   localparam logic [15:0] CTRL2_RST = 16'h0009;
   localparam logic [15:0] FLAGS_RST = 16'h4000;
   localparam logic [15:0] COND_RST = 16'h0000;
   localparam logic [15:0] COND_VALID = 16'h6FFF;
   localparam int CTRL2_SRC_BIT = 4;
   localparam int CTRL2_DRV_BIT = 5;
   localparam int UV_BIT = 14;

   // ----------------------------------------
   // Serial port counts
   // ----------------------------------------
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // Parked one below zero so the clock fall that closes a start is not counted as a bit
   localparam logic [3:0] BIT_START = 4'hF;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic reserved15;
      logic supply_undervoltage_flag;
      logic adaptive_boost_active_flag;
      logic reserved12;
      logic boost_overcurrent_flag;
      logic boost_overvoltage_flag;
      logic boost_startup_done_flag;
      logic amp_switching_flag;
      logic amp_clipping_flag;
      logic dsp_watchdog_flag;
      logic missing_ref_clock_flag;
      logic internal_clocks_stable_flag;
      logic amp_overcurrent_flag;
      logic amp_near_clip_flag;
      logic die_overtemp_flag;
      logic loop_locked_flag;
   } siu_cond_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } siu_line_t;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WR, ST_RD} siu_state_t;

endpackage : siu_pkg

// File: siu_sync.sv
`timescale 1ns/1ps
module siu_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   import siu_pkg::*;

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   if (WIDTH < 1) begin : g_chk
      $error("siu_sync width must be positive");
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end

   assign q = q_reg;

endmodule : siu_sync

// File: siu_core.sv
`timescale 1ns/1ps
module siu_core #(
   parameter logic [6:0] DEV_ADDR = 7'h34,
   parameter logic [15:0] CHIP_ID = 16'h1A5C  // Arbitrary identification value
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input siu_pkg::siu_cond_t cond_in,
   output logic irq_n_out,
   output logic irq_n_oe
);
   import siu_pkg::*;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_chk
      $error("siu_core device address falls in a reserved serial range");
   end

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   siu_line_t line_s;
   logic [15:0] cond_s;
   logic scl_q_reg, scl_q_next;
   logic sda_q_reg, sda_q_next;
   logic scl_rise, scl_fall, start_evt, stop_evt;
   siu_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] ptr_reg, ptr_next;
   logic [7:0] hi_reg, hi_next;
   logic byte_sel_reg, byte_sel_next;
   logic [15:0] tx_reg, tx_next;
   logic ack_reg, ack_next;
   logic drive_reg, drive_next;
   logic load_en;
   logic [7:0] load_addr;
   logic wr_en;
   logic [15:0] wr_data;
   logic [15:0] clr_vec;
   logic [15:0] cond_reg, cond_next;
   logic [15:0] flags_reg, flags_next;
   logic [15:0] mask_reg, mask_next;
   logic [15:0] ctrl2_reg, ctrl2_next;
   logic [15:0] set_vec;
   logic [15:0] irq_src;
   logic irq_reg, irq_next;
   logic first_reg;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   siu_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_line_sync (
      .clk(clk),
      .resetn(resetn),
      .d({scl_in, sda_in}),
      .q(line_s)
   );

   siu_sync #(.WIDTH(16), .RST_VAL(COND_RST)) u_cond_sync (
      .clk(clk),
      .resetn(resetn),
      .d(cond_in),
      .q(cond_s)
   );

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic logic [15:0] read_word(input logic [7:0] a);
      case (a)
         ADDR_ID: read_word = CHIP_ID;
         ADDR_COND: read_word = cond_reg;
         ADDR_FLAGS: read_word = flags_reg;
         ADDR_MASK: read_word = mask_reg;
         ADDR_CTRL2: read_word = ctrl2_reg;
         default: read_word = 16'h0000;
      endcase
   endfunction : read_word

   // High byte goes out first, most significant bit first
   function automatic logic tx_bit(input logic [15:0] w, input logic sel,
                                   input logic [2:0] idx);
      tx_bit = w[{~sel, ~idx}];
   endfunction : tx_bit

   // ----------------------------------------
   // Serial slave
   // ----------------------------------------
   assign scl_rise = line_s.scl & ~scl_q_reg;
   assign scl_fall = ~line_s.scl & scl_q_reg;
   assign start_evt = line_s.scl & scl_q_reg & sda_q_reg & ~line_s.sda;
   assign stop_evt = line_s.scl & scl_q_reg & ~sda_q_reg & line_s.sda;

   always_comb begin
      scl_q_next = line_s.scl;
      sda_q_next = line_s.sda;
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      hi_next = hi_reg;
      byte_sel_next = byte_sel_reg;
      ack_next = ack_reg;
      drive_next = drive_reg;
      load_en = 1'b0;
      load_addr = ptr_reg;
      wr_en = 1'b0;
      wr_data = {hi_reg, shift_reg};
      clr_vec = 16'h0000;
      if (start_evt) begin
         state_next = ST_ADDR;
         cnt_next = BIT_START;
         drive_next = 1'b0;
         byte_sel_next = 1'b0;
      end else if (stop_evt) begin
         state_next = ST_IDLE;
         drive_next = 1'b0;
      end else if (state_reg != ST_IDLE) begin
         if (scl_rise) begin
            if (cnt_reg < BIT_ACK) begin
               shift_next = {shift_reg[6:0], line_s.sda};
            end else begin
               ack_next = ~line_s.sda;
            end
         end
         if (scl_fall) begin
            if (cnt_reg == BIT_LAST) begin
               cnt_next = BIT_ACK;
               case (state_reg)
                  ST_ADDR: drive_next = (shift_reg[7:1] == DEV_ADDR);
                  ST_RD: drive_next = 1'b0;
                  default: drive_next = 1'b1;
               endcase
            end else if (cnt_reg == BIT_ACK) begin
               cnt_next = 4'h0;
               drive_next = 1'b0;
               case (state_reg)
                  ST_ADDR: begin
                     if (shift_reg[7:1] != DEV_ADDR) begin
                        state_next = ST_IDLE;
                     end else if (shift_reg[0]) begin
                        state_next = ST_RD;
                        load_en = 1'b1;
                        byte_sel_next = 1'b0;
                     end else begin
                        state_next = ST_REG;
                     end
                  end
                  ST_REG: begin
                     ptr_next = shift_reg;
                     state_next = ST_WR;
                     byte_sel_next = 1'b0;
                  end
                  ST_WR: begin
                     if (!byte_sel_reg) begin
                        hi_next = shift_reg;
                        byte_sel_next = 1'b1;
                     end else begin
                        wr_en = 1'b1;
                        ptr_next = ptr_reg + 8'h01;
                        byte_sel_next = 1'b0;
                     end
                  end
                  ST_RD: begin
                     if (!byte_sel_reg) begin
                        if (ack_reg) begin
                           byte_sel_next = 1'b1;
                        end else begin
                           state_next = ST_IDLE;
                        end
                     end else begin
                        // Only the bits that were sent are cleared, so late events survive
                        if (ptr_reg == ADDR_FLAGS) begin
                           clr_vec = tx_reg;
                        end
                        if (ack_reg) begin
                           ptr_next = ptr_reg + 8'h01;
                           load_en = 1'b1;
                           load_addr = ptr_reg + 8'h01;
                           byte_sel_next = 1'b0;
                        end else begin
                           state_next = ST_IDLE;
                        end
                     end
                  end
                  default: state_next = ST_IDLE;
               endcase
               if (state_next == ST_RD) begin
                  drive_next = ~tx_bit(load_en ? read_word(load_addr) : tx_reg,
                                       byte_sel_next, 3'h0);
               end
            end else begin
               cnt_next = cnt_reg + 4'h1;
               if (state_reg == ST_RD) begin
                  drive_next = ~tx_bit(tx_reg, byte_sel_reg, cnt_next[2:0]);
               end
            end
         end
      end
      tx_next = load_en ? read_word(load_addr) : tx_reg;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         hi_reg <= 8'h00;
         byte_sel_reg <= 1'b0;
         tx_reg <= 16'h0000;
         ack_reg <= 1'b0;
         drive_reg <= 1'b0;
      end else begin
         scl_q_reg <= scl_q_next;
         sda_q_reg <= sda_q_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         hi_reg <= hi_next;
         byte_sel_reg <= byte_sel_next;
         tx_reg <= tx_next;
         ack_reg <= ack_next;
         drive_reg <= drive_next;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = drive_reg;

   // ----------------------------------------
   // Status, flags, mask and pin control
   // ----------------------------------------
   always_comb begin
      cond_next = cond_s & COND_VALID;
      set_vec = cond_next ^ cond_reg;
      flags_next = (flags_reg & ~clr_vec) | set_vec;
      mask_next = mask_reg;
      ctrl2_next = ctrl2_reg;
      if (wr_en) begin
         case (ptr_reg)
            ADDR_ID: begin
               if (wr_data == RESET_MAGIC) begin
                  mask_next = MASK_RST;
                  ctrl2_next = CTRL2_RST;
               end
            end
            ADDR_MASK: mask_next = wr_data;
            ADDR_CTRL2: ctrl2_next = wr_data;
            default: mask_next = mask_reg;
         endcase
      end
      irq_src = ctrl2_reg[CTRL2_SRC_BIT] ? cond_reg : flags_reg;
      irq_next = |(irq_src & ~mask_reg & COND_VALID);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cond_reg <= COND_RST;
         flags_reg <= FLAGS_RST;
         mask_reg <= MASK_RST;
         ctrl2_reg <= CTRL2_RST;
         irq_reg <= 1'b0;
         first_reg <= 1'b1;
      end else begin
         cond_reg <= cond_next;
         flags_reg <= flags_next;
         mask_reg <= mask_next;
         ctrl2_reg <= ctrl2_next;
         irq_reg <= irq_next;
         first_reg <= 1'b0;
      end
   end

   // Open-drain only pulls low; push-pull drives both levels
   assign irq_n_out = ctrl2_reg[CTRL2_DRV_BIT] ? ~irq_reg : 1'b0;
   assign irq_n_oe = ctrl2_reg[CTRL2_DRV_BIT] ? 1'b1 : irq_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   chk_id_readback: assert property (
      (load_en && load_addr == ADDR_ID) |=> tx_reg == CHIP_ID)
      else $error("identity word not loaded");

   chk_magic_reset: assert property (
      (wr_en && ptr_reg == ADDR_ID && wr_data == RESET_MAGIC)
      |=> (mask_reg == MASK_RST && ctrl2_reg == CTRL2_RST))
      else $error("magic write did not restore defaults");

   chk_cond_live: assert property (
      ##1 cond_reg == ($past(cond_s) & COND_VALID))
      else $error("condition register not tracking inputs");

   chk_flag_sets: assert property (
      (set_vec != 16'h0000) |=> ((flags_reg & $past(set_vec)) == $past(set_vec)))
      else $error("changed condition did not set its flag");

   chk_flag_sticky: assert property (
      (clr_vec == 16'h0000) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
      else $error("flag dropped without a read");

   chk_power_flag: assert property (
      first_reg |-> (flags_reg[UV_BIT] && mask_reg == MASK_RST))
      else $error("power-on flag or mask default missing");

   chk_read_clear: assert property (
      (clr_vec != 16'h0000)
      |=> ((flags_reg & $past(clr_vec) & ~$past(set_vec)) == 16'h0000))
      else $error("read did not clear flags");

   chk_irq_masked: assert property (
      ((irq_src & ~mask_reg & COND_VALID) == 16'h0000) |=> !irq_reg)
      else $error("masked source raised interrupt");

   chk_reserved_zero: assert property (
      cond_reg[15] == 1'b0 && cond_reg[12] == 1'b0
      && flags_reg[15] == 1'b0 && flags_reg[12] == 1'b0)
      else $error("reserved bit reads one");

   chk_pin_drive: assert property (
      ctrl2_reg[CTRL2_DRV_BIT] ? (irq_n_oe && irq_n_out == !irq_reg)
                               : (irq_n_out == 1'b0 && irq_n_oe == irq_reg))
      else $error("interrupt pin drive mode wrong");

   chk_addr_ack: assert property (
      (scl_fall && state_reg == ST_ADDR && cnt_reg == BIT_LAST
       && shift_reg[7:1] == DEV_ADDR && !start_evt) |=> sda_oe)
      else $error("address not acknowledged");

   cov_flags_read: cover property (clr_vec != 16'h0000);
   cov_magic_write: cover property (wr_en && ptr_reg == ADDR_ID && wr_data == RESET_MAGIC);
   cov_irq_raised: cover property (!irq_reg ##1 irq_reg);
   cov_mask_write: cover property (wr_en && ptr_reg == ADDR_MASK);

endmodule : siu_core

// File: siu_host_model.sv
`timescale 1ns/1ps
module siu_host_model (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_drv
);
   // ----------------------------------------
   // Bus phases
   // ----------------------------------------
   // Quarter bit of 3 clk keeps scl low 6 clk, past the slave's 5 clk minimum
   localparam int QTR = 3;

   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic start_cond();
      sda_drv <= 1'b1;
      tick(QTR);
      scl <= 1'b1;
      tick(QTR);
      sda_drv <= 1'b0;
      tick(QTR);
      scl <= 1'b0;
      tick(QTR);
   endtask : start_cond

   task automatic stop_cond();
      sda_drv <= 1'b0;
      tick(QTR);
      scl <= 1'b1;
      tick(QTR);
      sda_drv <= 1'b1;
      tick(2 * QTR);
   endtask : stop_cond

   // Data only changes while scl is low, so no false start or stop is seen
   task automatic bit_io(input logic b, output logic r);
      sda_drv <= b;
      tick(QTR);
      scl <= 1'b1;
      tick(QTR);
      r = sda_line;
      tick(QTR);
      scl <= 1'b0;
      tick(QTR);
   endtask : bit_io

   // Eight bits MSB first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                          output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, ack_out);
   endtask : byte_io
endmodule : siu_host_model

// File: tb_status_interrupt_unit.sv
`timescale 1ns/1ps
module tb_status_interrupt_unit;
   import siu_pkg::*;
   localparam logic [6:0] DEV = 7'h34;
   localparam logic [15:0] ID_VAL = 16'h3C71;  // Arbitrary identification value
   logic clk;
   logic resetn;
   logic scl;
   logic host_sda;
   logic sda_w;
   logic sda_out;
   logic sda_oe;
   siu_cond_t cond;
   logic irq_n_out;
   logic irq_n_oe;
   logic [7:0] q;
   logic k;
   int n_fail;
   int n_tests;

   // ----------------------------------------
   // Wiring
   // ----------------------------------------
   // Pull-up on the data line: low while either party pulls it down
   assign sda_w = host_sda & (sda_oe ? sda_out : 1'b1);

   siu_host_model host_u (.clk(clk), .sda_line(sda_w), .scl(scl), .sda_drv(host_sda));

   siu_core #(.DEV_ADDR(DEV), .CHIP_ID(ID_VAL)) dut_u (
      .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .cond_in(cond), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------
   // Compare and access tasks
   // ----------------------------------------
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: word got %h exp %h", $time, got, exp);
      end
   endtask : chk16

   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: pin got %b exp %b", $time, got, exp);
      end
   endtask : chk1

   task automatic give_verdict();
      if (n_fail == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      logic [7:0] x;
      logic ak;
      host_u.start_cond();
      host_u.byte_io({DEV, 1'b0}, 1'b1, x, ak);
      chk1(ak, 1'b0);
      host_u.byte_io(a, 1'b1, x, ak);
      host_u.byte_io(d[15:8], 1'b1, x, ak);
      host_u.byte_io(d[7:0], 1'b1, x, ak);
      host_u.stop_cond();
   endtask : reg_wr

   // High byte first and acknowledged, low byte refused to end the read
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic ak;
      host_u.start_cond();
      host_u.byte_io({DEV, 1'b0}, 1'b1, q, ak);
      host_u.byte_io(a, 1'b1, q, ak);
      host_u.start_cond();
      host_u.byte_io({DEV, 1'b1}, 1'b1, q, ak);
      chk1(ak, 1'b0);
      host_u.byte_io(8'hFF, 1'b0, d[15:8], ak);
      host_u.byte_io(8'hFF, 1'b1, d[7:0], ak);
      host_u.stop_cond();
      chk16(d, exp);
   endtask : rd_chk

   task automatic set_cond(input logic [15:0] v);
      @(posedge clk);
      cond <= siu_cond_t'(v);
      host_u.tick(10);
   endtask : set_cond

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   // Tests take about 39400 cycles; over twice that means a hang
   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      give_verdict();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      n_fail = 0;
      n_tests = 0;
      resetn = 1'b0;
      cond = siu_cond_t'(16'h0000);
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      host_u.tick(5);
      rd_chk(ADDR_ID, ID_VAL);
      rd_chk(ADDR_COND, 16'h0000);
      rd_chk(ADDR_FLAGS, 16'h4000);
      rd_chk(ADDR_FLAGS, 16'h0000);
      rd_chk(ADDR_MASK, 16'hFFFF);
      rd_chk(ADDR_CTRL2, 16'h0009);
      for (int i = 0; i < 16; i++) begin
         set_cond(16'h0001 << i);
         rd_chk(ADDR_COND, (16'h0001 << i) & COND_VALID);
         rd_chk(ADDR_FLAGS, (16'h0001 << i) & COND_VALID);
         set_cond(16'h0000);
         rd_chk(ADDR_FLAGS, (16'h0001 << i) & COND_VALID);
      end
      // Only the clipping flag is unmasked; switching stays masked
      reg_wr(ADDR_MASK, 16'hFF7F);
      rd_chk(ADDR_MASK, 16'hFF7F);
      set_cond(16'h0100);
      chk1(irq_n_oe, 1'b0);
      set_cond(16'h0180);
      chk1(irq_n_oe, 1'b1);
      chk1(irq_n_out, 1'b0);
      reg_wr(ADDR_CTRL2, 16'h0029);
      chk1(irq_n_out, 1'b0);
      chk1(irq_n_oe, 1'b1);
      rd_chk(ADDR_FLAGS, 16'h0180);
      chk1(irq_n_out, 1'b1);
      reg_wr(ADDR_CTRL2, 16'h0039);
      chk1(irq_n_out, 1'b0);
      reg_wr(ADDR_COND, 16'h0000);
      reg_wr(ADDR_FLAGS, 16'hFFFF);
      rd_chk(ADDR_COND, 16'h0180);
      rd_chk(ADDR_FLAGS, 16'h0000);
      reg_wr(ADDR_ID, 16'hAA55);
      rd_chk(ADDR_MASK, 16'hFF7F);
      reg_wr(ADDR_ID, RESET_MAGIC);
      rd_chk(ADDR_MASK, 16'hFFFF);
      rd_chk(ADDR_CTRL2, 16'h0009);
      rd_chk(ADDR_ID, ID_VAL);
      chk1(irq_n_oe, 1'b0);
      // A foreign address is left unacknowledged
      host_u.start_cond();
      host_u.byte_io({DEV ^ 7'h01, 1'b0}, 1'b1, q, k);
      chk1(k, 1'b1);
      host_u.stop_cond();
      give_verdict();
   end
endmodule : tb_status_interrupt_unit
